// ==== fe_rx_pkg.sv ====
// constants, codes and state types of the 100 Mb/s receive decode path
// assumes a 125 MHz core clock and a 125 MHz symbol clock sampled as a pin
package fe_rx_pkg;

   // ***************************************************************
   // timing
   // ***************************************************************
   localparam int CLK_PERIOD_NS     = 8;
   localparam int SYM_PERIOD_NS     = 8;
   localparam int STAB_TIME_US      = 500;
   localparam int STAB_CYCLES       = (STAB_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int RECOV_TIME_US     = 10;
   localparam int RECOV_CYCLES      = (RECOV_TIME_US * 1000) / CLK_PERIOD_NS;
   localparam int SYNC_TIMEOUT_US   = 722;
   localparam int SYNC_TIMEOUT_SYMS = (SYNC_TIMEOUT_US * 1000) / SYM_PERIOD_NS;

   // ***************************************************************
   // descrambler and equalizer
   // ***************************************************************
   localparam logic [10:0] LFSR_RESET     = 11'h7ff;
   localparam logic [5:0]  LOCK_MATCH_BITS = 6'h3c;
   localparam logic [4:0]  IDLE_RUN_BITS   = 5'h1e;
   localparam logic [10:0] EQ_FAST_SYMS    = 11'h400;
   localparam logic [5:0]  GAIN_RESET      = 6'h20;
   localparam logic [5:0]  GAIN_MAX        = 6'h3f;
   localparam logic [5:0]  GAIN_FAST_STEP  = 6'h04;
   localparam logic [5:0]  GAIN_SLOW_STEP  = 6'h01;
   localparam logic [7:0]  MAG_TARGET      = 8'h60;

   // ***************************************************************
   // code-groups and nibbles
   // ***************************************************************
   localparam logic [4:0]  CG_IDLE  = 5'h1f;
   localparam logic [4:0]  CG_J     = 5'h18;
   localparam logic [4:0]  CG_K     = 5'h11;
   localparam logic [4:0]  CG_T     = 5'h0d;
   localparam logic [4:0]  CG_R     = 5'h07;
   localparam logic [14:0] SSD_WIN  = {CG_IDLE, CG_J, CG_K};
   localparam logic [3:0]  PREAMBLE = 4'h5;
   localparam logic [3:0]  ERR_NIB  = 4'he;
   localparam logic [2:0]  CG_LAST  = 3'h4;
   localparam int          FIFO_W   = 5;
   localparam int          FIFO_D   = 8;

   // mlt-3 level codes on the pins
   localparam logic [1:0]  LVL_ZERO = 2'h0;

   typedef enum logic [2:0] {
      LM_DOWN,
      LM_READY,
      LM_UP,
      LM_RECOVER,
      LM_FAIL
   } link_e;

endpackage

// ==== rx_fifo.sv ====
// small synchronous fifo with valid and ready on both sides
// assumes one clock and asynchronous active-low reset
`timescale 1ns/1ps
module rx_fifo #(
   parameter int W = 5,
   parameter int D = 8
) (
   input  wire logic         clk,
   input  wire logic         arst_n,
   input  wire logic         in_valid,
   output logic              in_ready,
   input  wire logic [W-1:0] in_data,
   output logic              out_valid,
   input  wire logic         out_ready,
   output logic [W-1:0]      out_data
);
   localparam int AW = $clog2(D);

   typedef struct packed {
      logic [D-1:0][W-1:0] mem;
      logic [AW-1:0]       wr;
      logic [AW-1:0]       rd;
      logic [AW:0]         cnt;
   } fifo_s;

   fifo_s s_r;
   fifo_s s_nxt;
   logic  push;
   logic  pop;

   assign in_ready  = (s_r.cnt != (AW+1)'(D));
   assign out_valid = (s_r.cnt != '0);
   assign out_data  = s_r.mem[s_r.rd];
   assign push      = in_valid & in_ready;
   assign pop       = out_valid & out_ready;

   function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
      ptr_inc = (p == (AW)'(D - 1)) ? '0 : p + 1'b1;
   endfunction

   always_comb begin
      s_nxt = s_r;
      if (push) begin
         s_nxt.mem[s_r.wr] = in_data;
         s_nxt.wr          = ptr_inc(s_r.wr);
      end
      if (pop) begin
         s_nxt.rd = ptr_inc(s_r.rd);
      end
      if (push && !pop) begin
         s_nxt.cnt = s_r.cnt + 1'b1;
      end else if (pop && !push) begin
         s_nxt.cnt = s_r.cnt - 1'b1;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   chk_fifo_bound: assert property (@(posedge clk) disable iff (!arst_n)
      s_r.cnt <= (AW+1)'(D))
      else $error("fifo count above depth");

endmodule

// ==== fe_rx_decode.sv ====
// 100 Mb/s receive decode path: mlt-3 to nrz, descrambler, 5b/4b, link monitor
// assumes line pins are asynchronous to clk and the symbol clock is a sampled pin
//
// What this block does
// - MLT-3 to NRZI, then NRZI to NRZ
// - deserialize, align 5-bit groups, map to nibbles
// - descrambler locks on received IDLE sequence
// - no nibbles decoded while unlocked
// - locked descrambler keeps checking its sync
// - lost sync reacquired from IDLE symbols
// - packet start needs IDLE then J then K
// - alignment kept from start to next start
// - J and K replaced by two 0101 nibbles
// - every packet code-group becomes a nibble, except T or IDLE, which wait on the next group
// - stop on T R or two IDLEs
// - symbols sampled on recovered clock
// - receive input from selected cable pair
// - equalizer steers gain toward target amplitude
// - large gain steps first, small later
// - standard link monitor state machine
// - optional link down on sync loss
// - add-ons off after reset
// - level change is one, no change zero
// - sixteen data groups, rest control or invalid
// - delimiters J K and T R codes
// - control inside data gives error nibble
`timescale 1ns/1ps
module fe_rx_decode #(
   parameter int STAB_CYCLES       = fe_rx_pkg::STAB_CYCLES,
   parameter int SYNC_TIMEOUT_SYMS = fe_rx_pkg::SYNC_TIMEOUT_SYMS
) (
   input  wire logic       clk,
   input  wire logic       arst_n,
   input  wire logic       sym_clk_pin,
   input  wire logic       pair_sel,
   input  wire logic [1:0] pair_a_lvl,
   input  wire logic [1:0] pair_b_lvl,
   input  wire logic [7:0] pair_a_mag,
   input  wire logic [7:0] pair_b_mag,
   input  wire logic       energy_det,
   input  wire logic       cfg_recovery_en,
   input  wire logic       cfg_sync_drop_en,
   input  wire logic       mac_ready,
   output logic [3:0]      rxd,
   output logic            rx_dv,
   output logic            rx_er,
   output logic            crs,
   output logic            scr_locked,
   output logic            tx_allow,
   output logic            link_up,
   output logic            link_restart,
   output logic [5:0]      vga_gain,
   output logic            overrun
);
   localparam logic [19:0] STAB_LAST  = 20'(STAB_CYCLES - 1);
   localparam logic [19:0] RECOV_LAST = 20'(fe_rx_pkg::RECOV_CYCLES - 1);
   localparam logic [19:0] SYNC_TO    = 20'(SYNC_TIMEOUT_SYMS);

   typedef struct packed {
      logic [2:0]        clk_sy;
      logic [3:0]        lvl_s1;
      logic [3:0]        lvl_s2;
      logic [15:0]       mag_s1;
      logic [15:0]       mag_s2;
      logic [1:0]        sel_s;
      logic [1:0]        energy_s;
      logic [1:0]        rec_s;
      logic [1:0]        drop_s;
      logic [1:0]        lvl_q;
      logic              nrzi_q;
      logic [10:0]       lfsr;
      logic              locked;
      logic [5:0]        match_cnt;
      logic [4:0]        ones_run;
      logic [19:0]       idle_tmr;
      logic [14:0]       sh;
      logic [2:0]        phase;
      logic              in_pkt;
      logic              t_pend;
      logic              i_pend;
      logic              pre_pend;
      logic              push_v;
      logic [4:0]        push_d;
      logic              overrun;
      logic [5:0]        gain;
      logic [10:0]       eq_cnt;
      fe_rx_pkg::link_e  lm;
      logic [19:0]       lm_tmr;
      logic              restart;
   } st_s;

   st_s        s_r;
   st_s        s_nxt;
   logic       fifo_in_ready;
   logic [4:0] fifo_out;
   logic       sym_edge;
   logic [1:0] lvl_cur;
   logic [7:0] mag_cur;

   // ***************************************************************
   // 5b to 4b lookup: bit 4 set for the sixteen data groups
   // ***************************************************************
   function automatic logic [4:0] cg_decode(input logic [4:0] cg);
      case (cg)
         5'h1e:   cg_decode = 5'h10;
         5'h09:   cg_decode = 5'h11;
         5'h14:   cg_decode = 5'h12;
         5'h15:   cg_decode = 5'h13;
         5'h0a:   cg_decode = 5'h14;
         5'h0b:   cg_decode = 5'h15;
         5'h0e:   cg_decode = 5'h16;
         5'h0f:   cg_decode = 5'h17;
         5'h12:   cg_decode = 5'h18;
         5'h13:   cg_decode = 5'h19;
         5'h16:   cg_decode = 5'h1a;
         5'h17:   cg_decode = 5'h1b;
         5'h1a:   cg_decode = 5'h1c;
         5'h1b:   cg_decode = 5'h1d;
         5'h1c:   cg_decode = 5'h1e;
         5'h1d:   cg_decode = 5'h1f;
         default: cg_decode = 5'h00;
      endcase
   endfunction

   assign sym_edge = s_r.clk_sy[1] & ~s_r.clk_sy[2];

   // pair choice is made only after pins and selector are synchronised
   assign lvl_cur = s_r.sel_s[1] ? s_r.lvl_s2[3:2] : s_r.lvl_s2[1:0];
   assign mag_cur = s_r.sel_s[1] ? s_r.mag_s2[15:8] : s_r.mag_s2[7:0];

   // ***************************************************************
   // next state
   // ***************************************************************
   always_comb begin
      logic       nrzi_b;
      logic       nrz_b;
      logic       ks;
      logic       plain;
      logic [14:0] sh_n;
      logic [4:0] code;
      logic [4:0] dec;
      logic       emit_v;
      logic [4:0] emit_d;
      logic [5:0] step;
      logic       energy;
      nrzi_b = 1'b0;
      nrz_b  = 1'b0;
      ks     = 1'b0;
      plain  = 1'b0;
      sh_n   = s_r.sh;
      code   = '0;
      dec    = '0;
      emit_v = 1'b0;
      emit_d = '0;
      step   = fe_rx_pkg::GAIN_SLOW_STEP;
      energy = s_r.energy_s[1];
      s_nxt  = s_r;
      s_nxt.restart  = 1'b0;
      s_nxt.clk_sy   = {s_r.clk_sy[1:0], sym_clk_pin};
      s_nxt.lvl_s1   = {pair_b_lvl, pair_a_lvl};
      s_nxt.lvl_s2   = s_r.lvl_s1;
      s_nxt.mag_s1   = {pair_b_mag, pair_a_mag};
      s_nxt.mag_s2   = s_r.mag_s1;
      s_nxt.sel_s    = {s_r.sel_s[0], pair_sel};
      s_nxt.energy_s = {s_r.energy_s[0], energy_det};
      s_nxt.rec_s    = {s_r.rec_s[0], cfg_recovery_en};
      s_nxt.drop_s   = {s_r.drop_s[0], cfg_sync_drop_en};

      // hold a word until the fifo takes it
      if (s_r.push_v && fifo_in_ready) begin
         s_nxt.push_v = 1'b0;
      end
      if (s_r.pre_pend && !s_nxt.push_v) begin
         s_nxt.push_v   = 1'b1;
         s_nxt.push_d   = {1'b0, fe_rx_pkg::PREAMBLE};
         s_nxt.pre_pend = 1'b0;
      end

      if (sym_edge) begin
         nrzi_b       = s_r.nrzi_q ^ (lvl_cur != s_r.lvl_q);
         nrz_b        = nrzi_b ^ s_r.nrzi_q;
         s_nxt.lvl_q  = lvl_cur;
         s_nxt.nrzi_q = nrzi_b;
         ks           = s_r.lfsr[10] ^ s_r.lfsr[8];
         plain        = nrz_b ^ ks;
         if (!s_r.locked) begin
            // idle is all ones, so the line bit inverted is the keystream
            s_nxt.lfsr = {s_r.lfsr[9:0], ~nrz_b};
            if (ks == ~nrz_b) begin
               if (s_r.match_cnt == fe_rx_pkg::LOCK_MATCH_BITS - 6'h01) begin
                  s_nxt.locked    = 1'b1;
                  s_nxt.match_cnt = '0;
                  s_nxt.idle_tmr  = '0;
               end else begin
                  s_nxt.match_cnt = s_r.match_cnt + 6'h01;
               end
            end else begin
               s_nxt.match_cnt = '0;
            end
         end else begin
            s_nxt.lfsr = {s_r.lfsr[9:0], ks};
            if (!plain) begin
               s_nxt.ones_run = '0;
            end else if (s_r.ones_run != fe_rx_pkg::IDLE_RUN_BITS) begin
               s_nxt.ones_run = s_r.ones_run + 5'h01;
            end
            if (s_r.ones_run == fe_rx_pkg::IDLE_RUN_BITS) begin
               s_nxt.idle_tmr = '0;
            end else if (s_r.idle_tmr == SYNC_TO) begin
               s_nxt.locked = 1'b0;
            end else begin
               s_nxt.idle_tmr = s_r.idle_tmr + 20'h00001;
            end

            sh_n     = {s_r.sh[13:0], plain};
            s_nxt.sh = sh_n;
            if (!s_r.in_pkt) begin
               if (sh_n == fe_rx_pkg::SSD_WIN) begin
                  s_nxt.in_pkt   = 1'b1;
                  s_nxt.phase    = '0;
                  s_nxt.pre_pend = 1'b1;
                  s_nxt.overrun  = 1'b0;
                  emit_v         = 1'b1;
                  emit_d         = {1'b0, fe_rx_pkg::PREAMBLE};
               end
            end else if (s_r.phase == fe_rx_pkg::CG_LAST) begin
               s_nxt.phase = '0;
               code        = sh_n[4:0];
               dec         = cg_decode(code);
               if (s_r.t_pend) begin
                  s_nxt.t_pend = 1'b0;
                  if (code == fe_rx_pkg::CG_R) begin
                     s_nxt.in_pkt = 1'b0;
                  end else begin
                     emit_v = 1'b1;
                     emit_d = {1'b1, fe_rx_pkg::ERR_NIB};
                  end
               end else if (s_r.i_pend) begin
                  s_nxt.i_pend = 1'b0;
                  if (code == fe_rx_pkg::CG_IDLE) begin
                     s_nxt.in_pkt = 1'b0;
                  end else begin
                     emit_v = 1'b1;
                     emit_d = {1'b1, fe_rx_pkg::ERR_NIB};
                  end
               end else if (code == fe_rx_pkg::CG_T) begin
                  s_nxt.t_pend = 1'b1;
               end else if (code == fe_rx_pkg::CG_IDLE) begin
                  s_nxt.i_pend = 1'b1;
               end else if (dec[4]) begin
                  emit_v = 1'b1;
                  emit_d = {1'b0, dec[3:0]};
               end else begin
                  emit_v = 1'b1;
                  emit_d = {1'b1, fe_rx_pkg::ERR_NIB};
               end
            end else begin
               s_nxt.phase = s_r.phase + 3'h1;
            end
         end

         // gain adaptation on the selected pair's amplitude
         if (s_r.eq_cnt < fe_rx_pkg::EQ_FAST_SYMS) begin
            step         = fe_rx_pkg::GAIN_FAST_STEP;
            s_nxt.eq_cnt = s_r.eq_cnt + 11'h001;
         end
         if (mag_cur > fe_rx_pkg::MAG_TARGET) begin
            s_nxt.gain = (s_r.gain > step) ? s_r.gain - step : '0;
         end else if (mag_cur < fe_rx_pkg::MAG_TARGET) begin
            s_nxt.gain = (s_r.gain < fe_rx_pkg::GAIN_MAX - step) ?
                         s_r.gain + step : fe_rx_pkg::GAIN_MAX;
         end
      end

      if (emit_v) begin
         if (s_nxt.push_v) begin
            s_nxt.overrun = 1'b1;
         end
         s_nxt.push_v = 1'b1;
         s_nxt.push_d = emit_d;
      end

      if (!energy) begin
         s_nxt.locked    = 1'b0;
         s_nxt.match_cnt = '0;
         s_nxt.eq_cnt    = '0;
      end
      if (!s_nxt.locked) begin
         s_nxt.in_pkt   = 1'b0;
         s_nxt.t_pend   = 1'b0;
         s_nxt.i_pend   = 1'b0;
         s_nxt.pre_pend = 1'b0;
      end

      // ************************************************************
      // link monitor
      // ************************************************************
      case (s_r.lm)
         fe_rx_pkg::LM_DOWN: begin
            s_nxt.lm_tmr = '0;
            if (energy) begin
               s_nxt.lm = fe_rx_pkg::LM_READY;
            end
         end
         fe_rx_pkg::LM_READY: begin
            if (!energy) begin
               s_nxt.lm = fe_rx_pkg::LM_DOWN;
            end else if (s_r.lm_tmr == STAB_LAST) begin
               s_nxt.lm = fe_rx_pkg::LM_UP;
            end else begin
               s_nxt.lm_tmr = s_r.lm_tmr + 20'h00001;
            end
         end
         fe_rx_pkg::LM_UP: begin
            s_nxt.lm_tmr = '0;
            if (s_r.drop_s[1] && !s_r.locked) begin
               s_nxt.lm = fe_rx_pkg::LM_DOWN;
            end else if (!energy) begin
               s_nxt.lm = s_r.rec_s[1] ? fe_rx_pkg::LM_RECOVER : fe_rx_pkg::LM_FAIL;
            end
         end
         fe_rx_pkg::LM_RECOVER: begin
            if (energy) begin
               s_nxt.lm = fe_rx_pkg::LM_UP;
            end else if (s_r.lm_tmr == RECOV_LAST) begin
               s_nxt.lm = fe_rx_pkg::LM_FAIL;
            end else begin
               s_nxt.lm_tmr = s_r.lm_tmr + 20'h00001;
            end
         end
         fe_rx_pkg::LM_FAIL: begin
            s_nxt.restart = 1'b1;
            s_nxt.lm      = fe_rx_pkg::LM_DOWN;
         end
         default: begin
            s_nxt.lm = fe_rx_pkg::LM_DOWN;
         end
      endcase
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         s_r      <= '0;
         s_r.lfsr <= fe_rx_pkg::LFSR_RESET;
         s_r.gain <= fe_rx_pkg::GAIN_RESET;
         s_r.lm   <= fe_rx_pkg::LM_DOWN;
      end else begin
         s_r <= s_nxt;
      end
   end

   // ***************************************************************
   // nibble buffer toward the mac
   // ***************************************************************
   rx_fifo #(
      .W (fe_rx_pkg::FIFO_W),
      .D (fe_rx_pkg::FIFO_D)
   ) u_fifo (
      .clk       (clk),
      .arst_n    (arst_n),
      .in_valid  (s_r.push_v),
      .in_ready  (fifo_in_ready),
      .in_data   (s_r.push_d),
      .out_valid (rx_dv),
      .out_ready (mac_ready),
      .out_data  (fifo_out)
   );

   assign rxd          = fifo_out[3:0];
   assign rx_er        = fifo_out[4];
   assign crs          = s_r.in_pkt;
   assign scr_locked   = s_r.locked;
   assign tx_allow     = s_r.locked;
   assign link_up      = (s_r.lm == fe_rx_pkg::LM_UP);
   assign link_restart = s_r.restart;
   assign vga_gain     = s_r.gain;
   assign overrun      = s_r.overrun;

   // ***************************************************************
   // checks
   // ***************************************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (!arst_n);

   chk_nrz_from_level: assert property (sym_edge && lvl_cur == s_r.lvl_q |=>
      s_r.nrzi_q == $past(s_r.nrzi_q))
      else $error("nrzi changed without a level change");
   chk_lock_after_run: assert property ($rose(s_r.locked) |->
      $past(s_r.match_cnt) == fe_rx_pkg::LOCK_MATCH_BITS - 6'h01)
      else $error("lock without full idle run");
   chk_unlocked_quiet: assert property (!s_r.locked |-> !s_r.in_pkt && !tx_allow)
      else $error("data path active while unlocked");
   chk_energy_unlock: assert property (!s_r.energy_s[1] |=> !s_r.locked && s_r.match_cnt == '0)
      else $error("lock held without energy");
   chk_ssd_window: assert property ($rose(s_r.in_pkt) |->
      s_r.sh == fe_rx_pkg::SSD_WIN && s_r.phase == '0)
      else $error("packet start without idle j k");
   chk_preamble_pair: assert property ($rose(s_r.in_pkt) |->
      s_r.push_v && s_r.push_d == {1'b0, fe_rx_pkg::PREAMBLE} && s_r.pre_pend)
      else $error("first preamble nibble missing");
   chk_gain_slow_step: assert property (sym_edge && s_r.eq_cnt >= fe_rx_pkg::EQ_FAST_SYMS &&
      mag_cur > fe_rx_pkg::MAG_TARGET && s_r.gain > 6'h01 && s_r.energy_s[1] |=>
      s_r.gain == $past(s_r.gain) - 6'h01)
      else $error("steady-state gain step wrong");
   chk_fail_restart: assert property (s_r.lm == fe_rx_pkg::LM_UP && !s_r.energy_s[1] &&
      !s_r.rec_s[1] && !(s_r.drop_s[1] && !s_r.locked) |=> ##1 link_restart)
      else $error("link fail did not restart");
   chk_sync_drop: assert property (s_r.lm == fe_rx_pkg::LM_UP && s_r.drop_s[1] &&
      !s_r.locked |=> s_r.lm == fe_rx_pkg::LM_DOWN)
      else $error("sync loss did not drop link");
   chk_addons_off: assert property ($past(!arst_n) |-> !s_r.rec_s[1] && !s_r.drop_s[1])
      else $error("add-ons active right after reset");

   cov_packet_start: cover property ($rose(s_r.in_pkt));
   cov_packet_end:   cover property ($fell(s_r.in_pkt) && s_r.locked);
   cov_link_up:      cover property ($rose(link_up));
   cov_recovery:     cover property (s_r.lm == fe_rx_pkg::LM_RECOVER ##1 s_r.lm == fe_rx_pkg::LM_UP);

endmodule

// ==== link_partner.sv ====
// link partner: scrambled mlt-3 code-group stream and its symbol clock
// assumes the bench pushes code-groups into cg_q; idle is sent otherwise
`timescale 1ns/1ps
module link_partner (
   input  wire logic       pair_sel,
   output logic            sym_clk_pin,
   output logic [1:0]      pair_a_lvl,
   output logic [1:0]      pair_b_lvl
);
   // ****************************************
   // line stream
   // ****************************************
   logic [4:0]  cg_q[$];
   logic [4:0]  cur_cg;
   logic [10:0] scr_r;
   logic [1:0]  lvl_r;
   logic [1:0]  ph_r;
   logic [1:0]  junk_r;
   logic        ks;
   int          bit_n;
   // the pair not selected changes level every symbol
   assign pair_a_lvl = pair_sel ? junk_r : lvl_r;
   assign pair_b_lvl = pair_sel ? lvl_r : junk_r;
   initial begin
      sym_clk_pin = 1'b0;
      scr_r       = 11'h2c5;
      lvl_r       = 2'h0;
      ph_r        = 2'h0;
      junk_r      = 2'h1;
      bit_n       = 5;
      forever begin
         #40 sym_clk_pin = 1'b1;
         #40 sym_clk_pin = 1'b0;
         if (bit_n == 5) begin
            cur_cg = (cg_q.size() > 0) ? cg_q.pop_front() : 5'h1f;
            bit_n  = 0;
         end
         ks    = scr_r[10] ^ scr_r[8];
         scr_r = {scr_r[9:0], ks};
         // a one steps the line through 0, +, 0, -
         if (cur_cg[4 - bit_n] ^ ks) begin
            ph_r  = ph_r + 2'h1;
            lvl_r = (ph_r == 2'h1) ? 2'h1 : ((ph_r == 2'h3) ? 2'h3 : 2'h0);
         end
         junk_r = ~junk_r;
         bit_n++;
      end
   end
endmodule

// ==== tb_top.sv ====
// self-checking bench of the 100 Mb/s receive decode path
// assumes link_partner drives the line; a queue predicts every nibble
`timescale 1ns/1ps
module tb_top;
   // ****************************************
   // signals and helpers
   // ****************************************
   logic        clk;
   logic        arst_n;
   logic        pair_sel;
   logic        energy_det;
   logic        rec_en;
   logic        drop_en;
   logic        tx_allow;
   logic        overrun;
   logic        mac_ready;
   logic [7:0]  mag_a;
   logic [7:0]  mag_b;
   logic        sym_clk;
   logic [1:0]  lvl_a;
   logic [1:0]  lvl_b;
   logic [3:0]  rxd;
   logic        rx_dv;
   logic        rx_er;
   logic        crs;
   logic        scr_locked;
   logic        link_up;
   logic        link_restart;
   logic [5:0]  vga_gain;
   logic [31:0] rng;
   logic [5:0]  exp_q[$];
   int          miscompares;
   int          n_compared;
   int          restarts;
   localparam logic [4:0] DCODE [16] = '{5'h1e, 5'h09, 5'h14, 5'h15, 5'h0a, 5'h0b,
      5'h0e, 5'h0f, 5'h12, 5'h13, 5'h16, 5'h17, 5'h1a, 5'h1b, 5'h1c, 5'h1d};
   link_partner lp (.pair_sel(pair_sel), .sym_clk_pin(sym_clk), .pair_a_lvl(lvl_a),
      .pair_b_lvl(lvl_b));
   fe_rx_decode #(.STAB_CYCLES(20), .SYNC_TIMEOUT_SYMS(200)) uut (.clk(clk),
      .arst_n(arst_n), .sym_clk_pin(sym_clk), .pair_sel(pair_sel), .pair_a_lvl(lvl_a),
      .pair_b_lvl(lvl_b), .pair_a_mag(mag_a), .pair_b_mag(mag_b), .energy_det(energy_det),
      .cfg_recovery_en(rec_en), .cfg_sync_drop_en(drop_en), .mac_ready(mac_ready), .rxd(rxd),
      .rx_dv(rx_dv), .rx_er(rx_er), .crs(crs), .scr_locked(scr_locked), .tx_allow(tx_allow),
      .link_up(link_up), .link_restart(link_restart), .vga_gain(vga_gain), .overrun(overrun));
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   function automatic logic [31:0] xs(input logic [31:0] v);
      logic [31:0] t;
      t = v ^ (v << 13);
      t = t ^ (t >> 17);
      return t ^ (t << 5);
   endfunction
   task automatic end_sim;
      $display("compared %0d miscompares %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   task automatic chk_word(input logic [5:0] e, input logic [5:0] g);
      n_compared++;
      if (g !== e) begin
         miscompares++;
         $display("wrong value nibble expected %h seen %h", e, g);
      end
   endtask
   task automatic chk_bit(input string nm, input logic e, input logic g);
      n_compared++;
      if (g !== e) begin
         miscompares++;
         $display("wrong value %s expected %b seen %b", nm, e, g);
      end
   endtask
   task automatic wait_hi(input string nm, ref logic s, input int lim);
      int k;
      k = 0;
      while (s !== 1'b1 && k < lim) begin
         @(posedge clk);
         k++;
      end
      chk_bit(nm, 1'b1, s);
      if (s !== 1'b1)
         end_sim;
   endtask
   // idle idle j k, n data groups (one control group at bad), then t r or two idles
   // waits, bounded, until the partner has taken every queued group
   task automatic drain;
      int k;
      k = 0;
      while (lp.cg_q.size() > 0 && k < 9000) begin
         @(posedge clk);
         k++;
      end
      chk_bit("line_drained", 1'b1, k < 9000);
      if (k >= 9000)
         end_sim;
   endtask
   task automatic frame(input int n, input int bad, input bit idle_end);
      int v;
      lp.cg_q.push_back(5'h1f);
      lp.cg_q.push_back(5'h1f);
      lp.cg_q.push_back(5'h18);
      lp.cg_q.push_back(5'h11);
      exp_q.push_back(6'h05);
      exp_q.push_back(6'h05);
      for (int i = 0; i < n; i++) begin
         v = (i < 16) ? i : int'(rng[3:0]);
         lp.cg_q.push_back((i == bad) ? 5'h04 : DCODE[v]);
         exp_q.push_back((i == bad) ? 6'h1e : {2'b00, 4'(v)});
      end
      lp.cg_q.push_back(idle_end ? 5'h1f : 5'h0d);
      lp.cg_q.push_back(idle_end ? 5'h1f : 5'h07);
      drain;
      repeat (200) @(posedge clk);
      chk_bit("frame_words_left", 1'b1, exp_q.size() == 0);
      chk_bit("crs_after_frame", 1'b0, crs);
      chk_bit("overrun", 1'b0, overrun);
      $display("frame of %0d groups done", n);
   endtask
   // ****************************************
   // random stimulus and nibble monitor
   // ****************************************
   always @(posedge clk) begin
      rng       <= xs(rng);
      mac_ready <= rng[0] | rng[1];
      mag_b     <= rng[15:8];
      mag_a     <= {1'b1, rng[22:16]};
      if (link_restart === 1'b1)
         restarts++;
      if (rx_dv === 1'b1 && mac_ready === 1'b1)
         chk_word((exp_q.size() > 0) ? exp_q.pop_front() : 6'h20, {1'b0, rx_er, rxd});
   end
   // ****************************************
   // main sequence
   // ****************************************
   initial begin
      arst_n      = 1'b0;
      pair_sel    = 1'b0;
      energy_det  = 1'b0;
      rec_en      = 1'b0;
      drop_en     = 1'b0;
      mac_ready   = 1'b0;
      mag_a       = 8'hff;
      mag_b       = 8'h00;
      rng         = 32'hf12c;
      miscompares = 0;
      n_compared  = 0;
      restarts    = 0;
      repeat (10) @(posedge clk);
      chk_bit("gain_reset", 1'b1, vga_gain === 6'h20);
      chk_bit("locked_reset", 1'b0, scr_locked);
      arst_n     <= 1'b1;
      energy_det <= 1'b1;
      wait_hi("lock", scr_locked, 3000);
      wait_hi("link_up", link_up, 200);
      frame(20, -1, 1'b0);
      frame(6, 3, 1'b1);
      chk_bit("gain_lowered", 1'b1, vga_gain < 6'h20);
      pair_sel <= 1'b1;
      repeat (100) @(posedge clk);
      frame(8, -1, 1'b0);
      energy_det <= 1'b0;
      repeat (50) @(posedge clk);
      chk_bit("unlocked", 1'b0, scr_locked);
      chk_bit("tx_blocked", 1'b0, tx_allow);
      chk_bit("restart_pulse", 1'b1, restarts == 1);
      energy_det <= 1'b1;
      wait_hi("relock", scr_locked, 3000);
      wait_hi("link_up_again", link_up, 200);
      frame(4, -1, 1'b0);
      rec_en <= 1'b1;
      repeat (5) @(posedge clk);
      energy_det <= 1'b0;
      repeat (20) @(posedge clk);
      energy_det <= 1'b1;
      wait_hi("relock_recovered", scr_locked, 3000);
      wait_hi("link_recovered", link_up, 200);
      chk_bit("no_restart", 1'b1, restarts == 1);
      // a long run of data zero groups has no idle run, so sync is lost
      drop_en <= 1'b1;
      repeat (50) lp.cg_q.push_back(5'h1e);
      drain;
      chk_bit("sync_lost", 1'b0, scr_locked);
      chk_bit("no_restart_drop", 1'b1, restarts == 1);
      wait_hi("relock_after_drop", scr_locked, 3000);
      wait_hi("link_after_drop", link_up, 200);
      repeat (11000) @(posedge clk);
      chk_bit("overrun_idle", 1'b0, overrun);
      $display("sync drop and steady gain done");
      end_sim;
   end
endmodule
